// ### core/itr_port.sv
// Inspection trigger/result port: cycle sequencing, strobe, missed trigger.
// Assumes software drives grab/result/done events through the register port.
//
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
//
// Cycle outline, one pass per accepted trigger:
//   idle   - ready high, waits for a synchronised trigger rise
//   grab   - ready and grab-end low until the image is in memory
//   proc   - waits for the result event, then drives the data lines unless the payload times out
//   settle - holds the data lines for the data-to-strobe delay
//   post   - strobe high (low after a timeout), waits for the done event to raise ready
//
// Register map, low bits used, upper read bits zero:
//   0 control  - handshake, missed enable, channel five choice,
//                never reset, setup mode, execution groups
//   1 result   - byte placed on the data lines
//   2 status   - one-hot state, acknowledge wait, sticky flags;
//                write one to clear a flag
//   3 force    - pin pattern shown in setup mode
//   4 size     - payload size in bits
//   5 events   - grab done, result ready, cycle done, overflow
//
// Hazards worth knowing:
//   - trigger and acknowledge pass two flops, so each pin edge
//     reaches the sequencer two cycles late
//   - a hardware set of a sticky flag wins over a software clear
//     in the same cycle, so no event is lost
//   - the strobe clear delay shares the cycle counter with the
//     settle delay; settle owns it while in that state
//   - setup mode only changes the pin image; the sequencer and
//     the flags keep running underneath
//   - events written outside the state that uses them are dropped,
//     except overflow, which is taken in any state
//   - with no handshake the strobe stands until the next trigger
//
// Contract
// - Trigger rise starts cycle, ready drops
// - Ready rises when processing finishes
// - One byte payload: handshake optional by setting
// - Over eight bits without handshake: timeout (none raised when execution groups set)
// - No handshake: strobe once data present
// - Trigger accepted only while ready high
// - Trigger while busy flags missed, if enabled
// - Ready falling edge marks application start
// - Grab-end low during image acquisition
// - Output data, then raise strobe
// - Ready high after execution and display
// - Next trigger clears strobe with ready
// - Setup mode forces every output
// - Strobe clears 300 us after acknowledge
// - Data cleared on start unless never-reset
// - React to trigger rising edge only
// - Channel five: overflow or missed trigger
module itr_port (
  input  wire logic                        clk_sys,     // System clock
  input  wire logic                        nrst,        // Async reset, active low
  input  wire logic                        trigger,     // Trigger from controller
  input  wire logic                        ack,         // Acknowledge from controller
  input  wire itr_pkg::itr_bus_s           bus,         // Register request
  output var  logic [31:0]                 rdata,       // Read data, cycle after read
  output var  itr_pkg::itr_pins_s          pins         // Outputs toward controller
);
  import itr_pkg::*;

  typedef struct packed {
    itr_state_e          state;
    logic [CTRL_W-1:0]   ctrl;
    logic [DATA_W-1:0]   result;
    logic [SIZE_W-1:0]   size;
    itr_pins_s           live;
    itr_pins_s           forced;
    itr_pins_s           pins;
    logic [CNT_W-1:0]    cnt;
    logic                ack_wait;
    logic                ovf;
    logic                missed;
    logic                timeout;
    logic [31:0]         rdata;
  } itr_st_s;

  itr_st_s st_reg;
  itr_st_s st_next;
  logic trig_lvl;
  logic trig_rise;
  logic ack_lvl;
  logic ack_rise;

  // Input synchronisers
  itr_edge u_trig (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .din     (trigger),
    .level   (trig_lvl),
    .rise    (trig_rise)
  );
  itr_edge u_ack (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .din     (ack),
    .level   (ack_lvl),
    .rise    (ack_rise)
  );

  // Handshake needed but not enabled
  function automatic logic need_hs_missing(
    input logic [CTRL_W-1:0] c, // Control word
    input logic [SIZE_W-1:0] s  // Payload size in bits
  );
    // Execution groups leave the mode to software
    need_hs_missing = !c[CB_GROUPS] && (s > ONE_BYTE_BITS) && !c[CB_HANDSHAKE];
  endfunction

  // Write strobe aimed at one register offset
  function automatic logic wr_hit(
    input itr_bus_s   b,  // Register request
    input logic [3:0] ofs // Register offset
  );
    wr_hit = b.wr && (b.addr == ofs);
  endfunction

  // Read strobe aimed at one register offset
  function automatic logic rd_hit(
    input itr_bus_s   b,  // Register request
    input logic [3:0] ofs // Register offset
  );
    rd_hit = b.rd && (b.addr == ofs);
  endfunction

  // Event write carrying one event bit
  function automatic logic evt_hit(
    input itr_bus_s    b,  // Register request
    input int unsigned pos // Event bit position
  );
    evt_hit = wr_hit(b, OFS_EVT) && b.wdata[pos];
  endfunction

  // Decoded event strobes from software
  logic evt_grab;   // Image moved into memory
  logic evt_result; // Results calculated
  logic evt_done;   // Execution and display done
  logic evt_ovf;    // Byte overflow seen
  assign evt_grab   = evt_hit(bus, EB_GRAB_DONE);
  assign evt_result = evt_hit(bus, EB_RESULT);
  assign evt_done   = evt_hit(bus, EB_DONE);
  assign evt_ovf    = evt_hit(bus, EB_OVF);

  // Trigger qualification against the ready line
  logic accept_trig; // Rising edge while ready
  logic refuse_trig; // Rising edge while busy
  assign accept_trig = trig_rise && st_reg.live.cycle_ready;
  assign refuse_trig = trig_rise && !st_reg.live.cycle_ready;

  // Acknowledge taken only while a handshaked strobe waits
  logic ack_take;    // Start of strobe clear delay
  logic clr_pending; // Strobe clear delay running
  assign ack_take    = st_reg.ack_wait && ack_rise && st_reg.live.result_valid_strobe;
  assign clr_pending = !st_reg.ack_wait && (st_reg.cnt != '0) && (st_reg.state != ITR_SETTLE);

  // Payload too wide for transfer without handshake
  logic hs_missing; // Result event would time out
  assign hs_missing = need_hs_missing(st_reg.ctrl, st_reg.size);

  // Status word: one-hot state, acknowledge wait and sticky flags
  logic [31:0] stat_word; // Read value of the status register
  assign stat_word = 32'({st_reg.state, st_reg.ack_wait, st_reg.ovf, st_reg.timeout, st_reg.missed});

  // Next-state logic: one copy of the whole state, filled in sections
  always_comb begin
    st_next = st_reg;
    st_next.rdata = '0;

    // Register writes: control, result byte, force pattern, size
    if (wr_hit(bus, OFS_CTRL)) begin
      st_next.ctrl = bus.wdata[CTRL_W-1:0];
    end else if (wr_hit(bus, OFS_DATA)) begin
      st_next.result = bus.wdata[DATA_W-1:0];
    end else if (wr_hit(bus, OFS_FORCE)) begin
      st_next.forced = bus.wdata[$bits(itr_pins_s)-1:0];
    end else if (wr_hit(bus, OFS_SIZE)) begin
      st_next.size = bus.wdata[SIZE_W-1:0];
    end else if (wr_hit(bus, OFS_STAT)) begin
      // Write one clears sticky flags; hardware sets below still win
      if (bus.wdata[SB_MISSED]) begin
        st_next.missed = 1'b0;
      end
      if (bus.wdata[SB_TIMEOUT]) begin
        st_next.timeout = 1'b0;
      end
      if (bus.wdata[SB_OVF]) begin
        st_next.ovf = 1'b0;
      end
    end

    // Register reads: data stand in the next cycle only, else zero
    if (rd_hit(bus, OFS_CTRL)) begin
      st_next.rdata = 32'(st_reg.ctrl);
    end else if (rd_hit(bus, OFS_DATA)) begin
      st_next.rdata = 32'(st_reg.result);
    end else if (rd_hit(bus, OFS_STAT)) begin
      st_next.rdata = stat_word;
    end else if (rd_hit(bus, OFS_FORCE)) begin
      st_next.rdata = 32'(st_reg.forced);
    end else if (rd_hit(bus, OFS_SIZE)) begin
      st_next.rdata = 32'(st_reg.size);
    end else begin
      st_next.rdata = '0;
    end

    // Trigger while busy: refused, flagged if enabled
    if (refuse_trig && st_reg.ctrl[CB_MISS_EN]) begin
      st_next.missed = 1'b1;
    end

    // Byte overflow reported by software
    if (evt_ovf) begin
      st_next.ovf = 1'b1;
    end

    // Sequencer: one pass per accepted trigger
    case (st_reg.state)
      ITR_IDLE: begin
        // Accept rising edge only while ready
        if (accept_trig) begin
          // Ready and strobe fall together
          st_next.live.cycle_ready = 1'b0;
          st_next.live.result_valid_strobe = 1'b0;
          st_next.live.grab_end_flag = 1'b0;
          st_next.ack_wait = 1'b0;
          // Old result cleared unless software keeps it
          if (!st_reg.ctrl[CB_NEVER_RST]) begin
            st_next.live.data = '0;
          end
          st_next.state = ITR_GRAB;
        end
      end

      ITR_GRAB: begin
        // Grab-end returns once image is in memory
        if (evt_grab) begin
          st_next.live.grab_end_flag = 1'b1;
          st_next.state = ITR_PROC;
        end
      end

      ITR_PROC: begin
        // Results ready: put data on lines first
        if (evt_result) begin
          if (hs_missing) begin
            // Payload too wide without handshake: no strobe
            st_next.timeout = 1'b1;
            st_next.state = ITR_POST;
          end else begin
            st_next.live.data = st_reg.result;
            st_next.cnt = CNT_W'(DATA_STROBE_CYC - 1);
            st_next.state = ITR_SETTLE;
          end
        end
      end

      ITR_SETTLE: begin
        // Data settle before strobe
        if (st_reg.cnt == '0) begin
          st_next.live.result_valid_strobe = 1'b1;
          // Handshake mode waits for the acknowledge
          st_next.ack_wait = st_reg.ctrl[CB_HANDSHAKE];
          st_next.state = ITR_POST;
        end else begin
          st_next.cnt = st_reg.cnt - 1'b1;
        end
      end

      ITR_POST: begin
        // Ready after execution and display done
        if (evt_done) begin
          st_next.live.cycle_ready = 1'b1;
          st_next.state = ITR_IDLE;
        end
      end

      default: begin
        // Unreachable codes fall back to idle
        st_next.state = ITR_IDLE;
      end
    endcase

    // Handshake: acknowledge starts the strobe clear delay
    // The sequencer keeps its own next state here, so a done event
    // in the same cycle is never lost
    if (ack_take) begin
      st_next.cnt = CNT_W'(ACK_CLR_CYC - 1);
      st_next.ack_wait = 1'b0;
    end

    // Count the clear delay down, drop the strobe on the last step
    if (clr_pending) begin
      st_next.cnt = st_reg.cnt - 1'b1;
      if (st_reg.cnt == CNT_W'(1)) begin
        st_next.live.result_valid_strobe = 1'b0;
      end
    end

    // Status lines follow the sticky flags
    st_next.live.missed_trigger = st_next.missed;
    st_next.live.timeout_err = st_next.timeout;

    // Pin image; channel five also reports overflow or missed trigger
    st_next.pins = st_next.live;
    if (st_reg.ctrl[CB_CH5_MISS]) begin
      st_next.pins.data[CH5_BIT] = st_next.live.data[CH5_BIT] | st_next.missed;
    end else begin
      st_next.pins.data[CH5_BIT] = st_next.live.data[CH5_BIT] | st_next.ovf;
    end

    // Setup mode: the forced pattern replaces every pin
    if (st_reg.ctrl[CB_SETUP]) begin
      st_next.pins = st_reg.forced;
    end
  end

  // State register; reset leaves the port ready with grab-end high
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      // Everything clear, then the two lines that idle high
      st_reg <= '0;
      st_reg.state <= ITR_IDLE;
      st_reg.live.cycle_ready <= 1'b1;
      st_reg.live.grab_end_flag <= 1'b1;
      st_reg.pins.cycle_ready <= 1'b1;
      st_reg.pins.grab_end_flag <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from flops
  assign pins = st_reg.pins;
  assign rdata = st_reg.rdata;
  // Unused level outputs of synchronisers
  logic unused_lvl;
  assign unused_lvl = trig_lvl ^ ack_lvl;
endmodule
`default_nettype wire

// ### core/itr_pkg.sv
// Package for the inspection trigger/result port.
// Assumes a single 50 MHz system clock; used by itr_port, the checker and the testbench.
package itr_pkg;

  // System clock rate
  localparam int unsigned CLK_HZ = 50_000_000;
  // Strobe clear delay after acknowledge, in microseconds
  localparam int unsigned ACK_CLR_US = 300;
  localparam int unsigned ACK_CLR_CYC = (ACK_CLR_US * (CLK_HZ / 1_000_000));
  // Data output to strobe delay, in microseconds
  localparam int unsigned DATA_STROBE_US = 1200;
  localparam int unsigned DATA_STROBE_CYC = (DATA_STROBE_US * (CLK_HZ / 1_000_000));
  // Widths
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CNT_W = 17;
  localparam int unsigned SIZE_W = 8;
  // Payload limit for no-handshake transfer, in bits
  localparam logic [SIZE_W-1:0] ONE_BYTE_BITS = 8'h08;

  // Register offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_DATA = 4'h1;
  localparam logic [3:0] OFS_STAT = 4'h2;
  localparam logic [3:0] OFS_FORCE = 4'h3;
  localparam logic [3:0] OFS_SIZE = 4'h4;
  localparam logic [3:0] OFS_EVT = 4'h5;

  // Control bit positions
  localparam int unsigned CB_HANDSHAKE = 0;
  localparam int unsigned CB_MISS_EN = 1;
  localparam int unsigned CB_CH5_MISS = 2;
  localparam int unsigned CB_NEVER_RST = 3;
  localparam int unsigned CB_SETUP = 4;
  localparam int unsigned CB_GROUPS = 5;
  localparam int unsigned CTRL_W = 6;

  // Event command bit positions
  localparam int unsigned EB_GRAB_DONE = 0;
  localparam int unsigned EB_RESULT = 1;
  localparam int unsigned EB_DONE = 2;
  localparam int unsigned EB_OVF = 3;
  localparam int unsigned EB_CLR = 4;

  // Status write-one-to-clear bit positions
  localparam int unsigned SB_MISSED = 0;
  localparam int unsigned SB_TIMEOUT = 1;
  localparam int unsigned SB_OVF = 2;

  // Channel five bit of the data lines
  localparam int unsigned CH5_BIT = 4;

  // Cycle sequencer states
  typedef enum logic [4:0] {
    ITR_IDLE   = 5'b00001,
    ITR_GRAB   = 5'b00010,
    ITR_PROC   = 5'b00100,
    ITR_SETTLE = 5'b01000,
    ITR_POST   = 5'b10000
  } itr_state_e;

  // Register port request
  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } itr_bus_s;

  // Pins toward the controller
  typedef struct packed {
    logic              cycle_ready;
    logic              grab_end_flag;
    logic              result_valid_strobe;
    logic              missed_trigger;
    logic              timeout_err;
    logic [DATA_W-1:0] data;
  } itr_pins_s;

endpackage

// ### core/itr_edge.sv
// Two-flop synchroniser with rising-edge detector.
// Assumes the input is already a clean level from an isolator.
`timescale 1ns/1ps
`default_nettype none
module itr_edge (
  input  wire logic clk_sys, // System clock
  input  wire logic nrst,    // Async reset, active low
  input  wire logic din,     // Raw input level
  output var  logic level,   // Synchronised level
  output var  logic rise     // One-cycle rising pulse
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } itr_sync_s;

  itr_sync_s st_reg;
  itr_sync_s st_next;

  // Next state: shift chain, first flop read only by second
  always_comb begin
    st_next = st_reg;
    st_next.s1 = din;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
  end

  // State register
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // One event per edge
  assign level = st_reg.s2;
  assign rise = st_reg.s2 & ~st_reg.s3;
endmodule
`default_nettype wire

// ### verif/itr_port_asserts.sv
// Checker for the trigger/result port pins.
// Assumes it is bound to itr_port and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module itr_port_asserts (
  input wire logic               clk_sys, // System clock
  input wire logic               nrst,    // Async reset, active low
  input wire logic               trigger, // Trigger input
  input wire logic               ack,     // Acknowledge input
  input wire itr_pkg::itr_bus_s  bus,     // Register request
  input wire logic [31:0]        rdata,   // Read data
  input wire itr_pkg::itr_pins_s pins     // Pin outputs
);
  import itr_pkg::*;
  logic [CTRL_W-1:0] ctrl_reg; // Control shadow
  logic [7:0]        size_reg; // Size shadow
  logic [15:0]       cnt_reg;  // Cycles since acknowledge
  logic              ack_reg;  // Acknowledge delayed
  // Shadows of control and size, acknowledge timer
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg <= '0;
      size_reg <= '0;
      cnt_reg  <= '0;
      ack_reg  <= 1'b0;
    end else begin
      ack_reg <= ack;
      if (bus.wr && bus.addr == OFS_CTRL) ctrl_reg <= bus.wdata[CTRL_W-1:0];
      if (bus.wr && bus.addr == OFS_SIZE) size_reg <= bus.wdata[7:0];
      if (ack && !ack_reg && pins.result_valid_strobe && ctrl_reg[CB_HANDSHAKE]) cnt_reg <= 16'h0001;
      else if (cnt_reg != 16'h0000 && cnt_reg != 16'hFFFF) cnt_reg <= cnt_reg + 16'h0001;
    end
  end
  // Setup mode overrides every pin, so nothing is checked there
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst || ctrl_reg[CB_SETUP]);
  trig_start_a: assert property (
    $rose(trigger) && pins.cycle_ready |-> ##[2:6] !pins.cycle_ready) else $error("ready stayed high");
  ready_fall_a: assert property (
    $fell(pins.cycle_ready) |-> !pins.grab_end_flag && !pins.result_valid_strobe) else $error("bad start");
  data_clr_a: assert property (
    $fell(pins.cycle_ready) && !ctrl_reg[CB_NEVER_RST] |-> (pins.data & 8'hEF) == 8'h00) else $error("data kept");
  strobe_hold_a: assert property (
    pins.result_valid_strobe |=> !pins.result_valid_strobe || (pins.data & 8'hEF) == ($past(pins.data) & 8'hEF))
    else $error("data moved under strobe");
  strobe_rise_a: assert property (
    $rose(pins.result_valid_strobe) |-> $stable(pins.data) && !pins.cycle_ready) else $error("bad strobe rise");
  ack_clr_a: assert property (
    cnt_reg == 16'd14990 |-> pins.result_valid_strobe ##30 !pins.result_valid_strobe) else $error("strobe clear time");
  tmo_a: assert property (
    bus.wr && bus.addr == OFS_EVT && bus.wdata[EB_RESULT] && size_reg > ONE_BYTE_BITS && !pins.cycle_ready
    && !ctrl_reg[CB_HANDSHAKE] && !ctrl_reg[CB_GROUPS] |-> ##[1:3] pins.timeout_err && !pins.result_valid_strobe)
    else $error("no timeout");
  miss_a: assert property (
    $rose(trigger) && !pins.cycle_ready && ctrl_reg[CB_MISS_EN] |-> ##[2:6] pins.missed_trigger)
    else $error("missed trigger not flagged");
endmodule
bind itr_port itr_port_asserts chk_u (.clk_sys(clk_sys), .nrst(nrst), .trigger(trigger), .ack(ack),
  .bus(bus), .rdata(rdata), .pins(pins));
`default_nettype wire

// ### verif/itr_plc_model.sv
// Controller model: trigger pulses and acknowledge of each strobe.
// Assumes one 50 MHz clock shared with the port.
`timescale 1ns/1ps
`default_nettype none
module itr_plc_model (
  input  wire logic clk_sys, // System clock
  input  wire logic nrst,    // Async reset, active low
  input  wire logic go,      // Request one trigger pulse
  input  wire logic strobe,  // Result strobe from the port
  output var  logic trigger, // Trigger toward the port
  output var  logic ack,     // Acknowledge toward the port
  output var  logic busy     // Pulse still running
);
  localparam int HOLD_CYC = 50000; // 1 ms at 50 MHz
  int hold_cnt;
  // Trigger held for its minimum width, ack follows the strobe
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      hold_cnt <= 0;
      trigger  <= 1'b0;
      ack      <= 1'b0;
    end else begin
      ack <= strobe;
      if (go) begin
        hold_cnt <= HOLD_CYC;
        trigger  <= 1'b1;
      end else if (hold_cnt > 1) hold_cnt <= hold_cnt - 1;
      else begin
        hold_cnt <= 0;
        trigger  <= 1'b0;
      end
    end
  end
  // Busy while the pulse lasts
  always_comb busy = (hold_cnt != 0);
endmodule
`default_nettype wire

// ### verif/itr_port_tb_top.sv
// Testbench for the trigger/result port with a controller model.
// Assumes package, port, checker and controller model compiled first.
`timescale 1ns/1ps
`default_nettype none
module itr_port_tb_top;
  import itr_pkg::*;
  logic        clk_sys;
  logic        nrst;
  logic        go;
  logic        trigger;
  logic        ack;
  logic        busy;
  itr_bus_s    bus;
  logic [31:0] rdata;
  itr_pins_s   pins;
  int          failures;
  int          n_tests;
  int          n;
  logic [7:0]  r;
  logic [7:0]  exp_q[$]; // Bytes expected on the data lines
  itr_port dut_u (.clk_sys(clk_sys), .nrst(nrst), .trigger(trigger), .ack(ack), .bus(bus), .rdata(rdata),
    .pins(pins));
  itr_plc_model plc_u (.clk_sys(clk_sys), .nrst(nrst), .go(go), .strobe(pins.result_valid_strobe),
    .trigger(trigger), .ack(ack), .busy(busy));
  // Free running clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk_sys);
    bus.rd <= 1'b0;
    #1 chk("rdata", rdata, exp);
  endtask
  task automatic wt(input int b, input logic v, input int lim);
    n = 0;
    while (pins[b] !== v && n < lim) begin
      @(posedge clk_sys);
      #1 n++;
    end
    chk("pin wait", n < lim, 1);
  endtask
  task automatic pulse();
    while (busy !== 1'b0) @(posedge clk_sys);
    @(posedge clk_sys);
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
  endtask
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (130000) @(posedge clk_sys);
    failures++;
    give_verdict();
  end
  // Main sequence: handshake cycle with missed trigger, timeout cycle, setup force
  initial begin
    nrst = 1'b0;
    go = 1'b0;
    bus = '0;
    failures = 0;
    n_tests = 0;
    void'($urandom(32'hAA96));
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    #1 chk("reset pins", pins, 13'h1800);
    rd(OFS_STAT, 32'h10);
    rd(4'hF, 32'h0);
    wr(OFS_CTRL, 32'h3);
    wr(OFS_SIZE, 32'h8);
    pulse();
    wt(12, 1'b0, 20);
    chk("grab strobe", pins[11:10], 2'b00);
    chk("data clear", pins.data, 8'h00);
    r = $urandom;
    exp_q.push_back(r);
    wr(OFS_DATA, {24'h0, r});
    wr(OFS_EVT, 32'h1);
    wt(11, 1'b1, 10);
    wr(OFS_EVT, 32'h2);
    repeat (50100) @(posedge clk_sys);
    pulse();
    wt(9, 1'b1, 20);
    wt(10, 1'b1, 12000);
    chk("data", pins.data, exp_q.pop_front());
    chk("ready", pins.cycle_ready, 1'b0);
    wt(10, 1'b0, 15100);
    chk("ack delay", n > 14900, 1'b1);
    wr(OFS_EVT, 32'h4);
    wt(12, 1'b1, 10);
    rd(OFS_STAT, 32'h11);
    wr(OFS_STAT, 32'h1);
    rd(OFS_STAT, 32'h10);
    wr(OFS_CTRL, 32'h2);
    wr(OFS_SIZE, 32'h10);
    pulse();
    wt(12, 1'b0, 20);
    wr(OFS_EVT, 32'h1);
    wr(OFS_EVT, 32'h2);
    wt(8, 1'b1, 10);
    chk("no strobe", pins.result_valid_strobe, 1'b0);
    wr(OFS_EVT, 32'h4);
    wt(12, 1'b1, 10);
    wr(OFS_EVT, 32'h8);
    #1 chk("ch5 ovf", pins.data[CH5_BIT], 1'b1);
    wr(OFS_CTRL, 32'h6);
    @(posedge clk_sys);
    #1 chk("ch5 missed", pins.data[CH5_BIT], 1'b0);
    rd(OFS_STAT, 32'h16);
    r = $urandom;
    wr(OFS_CTRL, 32'h10);
    wr(OFS_FORCE, {19'h0, 5'h1C, r});
    @(posedge clk_sys);
    #1 chk("forced", pins, {5'h1C, r});
    give_verdict();
  end
endmodule
`default_nettype wire
